// ==== design/cpr_code_reg.sv ====
// One channel code register with clear priority over write
`timescale 1ns/1ps
`include "cpr_params.svh"

module cpr_code_reg #(
  parameter int CODE_W = 12
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              clear,
  input  wire logic              wr_en,
  input  wire logic [CODE_W-1:0] wdata,
  output logic      [CODE_W-1:0] code
);

  // Only the documented code width is served by the bit layout
  if (CODE_W != 12) begin : g_bad_code_w
    $error("cpr_code_reg: CODE_W must be 12");
  end

  // Clear wins over a write landing in the same cycle
  always_ff @(posedge mclk) begin
    if (!nrst || clear) begin
      code <= `CPR_CODE_RESET;
    end else if (wr_en) begin
      code <= wdata;
    end
  end

endmodule : cpr_code_reg

// ==== design/cpr_params.svh ====
// Register offsets, field positions and reset values of the channel register slice
`ifndef CPR_PARAMS_SVH
`define CPR_PARAMS_SVH

`define CPR_ADDR_W          7
`define CPR_DATA_W          16
`define CPR_ADDR_CHAN_MODE  7'h05
`define CPR_ADDR_SOFT_RESET 7'h06
`define CPR_ADDR_CH0_CODE   7'h07
`define CPR_ADDR_CH1_CODE   7'h08
`define CPR_ADDR_CH2_CODE   7'h09
`define CPR_ADDR_CH3_CODE   7'h0a
`define CPR_PWR_LSB         8
`define CPR_PWR_MSB         11
`define CPR_CLR_BIT         12
`define CPR_RST_BIT         8
`define CPR_CODE_LSB        4
`define CPR_CODE_MSB        15
`define CPR_REG_RESET       16'h0000
`define CPR_PWR_RESET       4'h0
`define CPR_CODE_RESET      12'h000

`endif

// ==== design/cpr_pkg.sv ====
// Types shared by the channel register slice
package cpr_pkg;

  // One register access handed over by the serial front end
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [6:0]  addr;
    logic [15:0] wdata;
  } cpr_req_t;

  // Register read answer
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } cpr_rsp_t;

endpackage : cpr_pkg

// ==== design/cpr_regs.sv ====
// Channel power, soft reset and channel code registers behind the serial register port
// Notes on behaviour
// - Bits 11:8 of the mode register give per-channel power, bit 8 is channel 0.
// - A power bit at zero turns its channel off; one turns it on.
// - Data-clear bit 12 resets all channel codes and latch load bits only.
// - Full-reset bit 8 resets every register except CRC enable and reference select.
// - Both action bits clear themselves when the setting transaction ends.
// - Channel code is a 12-bit field at bits 15:4, reset zero, bits 3:0 reserved.
`timescale 1ns/1ps
`include "cpr_params.svh"

module cpr_regs #(
  parameter int NUM_CH = 4
) (
  input  wire logic            mclk,
  input  wire logic            nrst,
  input  wire cpr_pkg::cpr_req_t req,
  input  wire logic            xfer_done,
  output cpr_pkg::cpr_rsp_t    rsp,
  output logic [NUM_CH-1:0]    channel_power_on,
  output logic [11:0]          channel0_code_value,
  output logic [11:0]          channel1_code_value,
  output logic [11:0]          channel2_code_value,
  output logic [11:0]          channel3_code_value,
  output logic                 data_clear_strobe,
  output logic                 full_reset_strobe
);

  // The register map carries exactly four channels
  if (NUM_CH != 4) begin : g_bad_num_ch
    $error("cpr_regs: NUM_CH must be 4");
  end

  // Address match shared by write and read decoding
  function automatic logic addr_is(input logic [6:0] a, input logic [6:0] target);
    addr_is = (a == target);
  endfunction : addr_is

  logic        pend_clr;
  logic        pend_rst;
  logic        next_pend_clr;
  logic        next_pend_rst;
  logic [3:0]  next_power;
  logic [11:0] codes [4];
  logic [3:0]  code_wr;

  // Write decode
  wire wr_mode   = req.wr && addr_is(req.addr, `CPR_ADDR_CHAN_MODE);
  wire wr_soft   = req.wr && addr_is(req.addr, `CPR_ADDR_SOFT_RESET);
  wire set_clr   = wr_soft && req.wdata[`CPR_CLR_BIT];
  wire set_rst   = wr_soft && req.wdata[`CPR_RST_BIT];

  // self-clear at end
  // A request written in the finishing cycle still acts at that end
  wire act_clr   = (pend_clr || set_clr) && xfer_done;
  wire act_rst   = (pend_rst || set_rst) && xfer_done;
  assign next_pend_clr = (pend_clr || set_clr) && !xfer_done;
  assign next_pend_rst = (pend_rst || set_rst) && !xfer_done;

  // data clear scope
  // Full reset also covers the code registers, so it joins the clear
  wire codes_clear = act_clr || act_rst;

  // power bit field
  // Reset action wins over a power write in the same cycle
  assign next_power = act_rst ? `CPR_PWR_RESET :
                      wr_mode ? req.wdata[`CPR_PWR_MSB:`CPR_PWR_LSB] : channel_power_on;

  // Pending actions wait for the end of their transaction
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pend_clr <= 1'b0;
      pend_rst <= 1'b0;
    end else begin
      pend_clr <= next_pend_clr;
      pend_rst <= next_pend_rst;
    end
  end

  // channel power level
  // Power enables drive the output stages directly, so they sit in flops
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      channel_power_on <= `CPR_PWR_RESET;
    end else begin
      channel_power_on <= next_power;
    end
  end

  // Strobes tell the latch control and configuration logic to reset themselves;
  // that logic keeps CRC enable and reference select on a full reset
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      data_clear_strobe <= 1'b0;
      full_reset_strobe <= 1'b0;
    end else begin
      data_clear_strobe <= codes_clear;
      full_reset_strobe <= act_rst;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ch
      assign code_wr[gi] = req.wr &&
        addr_is(req.addr, 7'(`CPR_ADDR_CH0_CODE + gi));
      cpr_code_reg #(
        .CODE_W (12)
      ) u_code (
        .mclk  (mclk),
        .nrst  (nrst),
        .clear (codes_clear),
        .wr_en (code_wr[gi]),
        .wdata (req.wdata[`CPR_CODE_MSB:`CPR_CODE_LSB]),
        .code  (codes[gi])
      );
    end
  endgenerate

  assign channel0_code_value = codes[0];
  assign channel1_code_value = codes[1];
  assign channel2_code_value = codes[2];
  assign channel3_code_value = codes[3];

  // reserved read zero
  // Read selection; action bits and reserved bits return zero
  wire [3:0]  rd_ch  = req.addr[3:0] - 4'(`CPR_ADDR_CH0_CODE);
  wire        rd_cod = (req.addr >= `CPR_ADDR_CH0_CODE) && (req.addr <= `CPR_ADDR_CH3_CODE);
  wire [15:0] rd_mux = addr_is(req.addr, `CPR_ADDR_CHAN_MODE) ?
                         {4'h0, channel_power_on, 8'h00} :
                       rd_cod ? {codes[rd_ch[1:0]], 4'h0} : `CPR_REG_RESET;

  // Read answer one cycle after the request
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rsp <= '0;
    end else begin
      rsp.valid <= req.rd;
      rsp.data  <= req.rd ? rd_mux : `CPR_REG_RESET;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_clr_request;
    set_clr && !xfer_done;
  endsequence

  sequence s_clr_waits;
    pend_clr && !xfer_done;
  endsequence

  sequence s_rst_request;
    set_rst && !xfer_done;
  endsequence

  sequence s_rst_waits;
    pend_rst && !xfer_done;
  endsequence

  // Checks run outside reset only; every answer shows one edge after its request
  AST_PWR_WRITE: assert property (
    (wr_mode && !act_rst) |=>
      channel_power_on == $past(req.wdata[`CPR_PWR_MSB:`CPR_PWR_LSB]))
    else $error("power bits not taken from bits 11:8");

  AST_MODE_READ: assert property (
    (req.rd && addr_is(req.addr, `CPR_ADDR_CHAN_MODE)) |=>
      (rsp.valid && rsp.data[`CPR_PWR_MSB:`CPR_PWR_LSB] == $past(channel_power_on)))
    else $error("power bits not read back at bits 11:8");

  AST_PWR_HOLD: assert property (
    (!wr_mode && !act_rst) |=> $stable(channel_power_on))
    else $error("power bits changed without cause");

  AST_CLR_CODES: assert property (
    (act_clr && !act_rst && !wr_mode) |=>
      (channel0_code_value == `CPR_CODE_RESET && channel1_code_value == `CPR_CODE_RESET &&
       channel2_code_value == `CPR_CODE_RESET && channel3_code_value == `CPR_CODE_RESET &&
       $stable(channel_power_on) && data_clear_strobe && !full_reset_strobe))
    else $error("data clear scope wrong");

  AST_RST_ALL: assert property (
    act_rst |=> (channel_power_on == `CPR_PWR_RESET &&
                 channel0_code_value == `CPR_CODE_RESET && channel1_code_value == `CPR_CODE_RESET &&
                 channel2_code_value == `CPR_CODE_RESET && channel3_code_value == `CPR_CODE_RESET &&
                 full_reset_strobe && data_clear_strobe))
    else $error("full reset did not clear registers");

  AST_CLR_PENDS: assert property (
    s_clr_request ##1 s_clr_waits [*2] |-> !data_clear_strobe)
    else $error("data clear acted before transaction end");

  AST_RST_PENDS: assert property (
    s_rst_request ##1 s_rst_waits [*2] |-> !full_reset_strobe)
    else $error("full reset acted before transaction end");

  AST_SELF_CLEAR: assert property (
    xfer_done |=> (!pend_clr && !pend_rst))
    else $error("action bit did not clear itself");

  AST_STROBE_AT_END: assert property (
    (data_clear_strobe || full_reset_strobe) |-> $past(xfer_done))
    else $error("reset action outside a transaction end");

  AST_CODE_WRITE: assert property (
    (code_wr[0] && !codes_clear) |=>
      channel0_code_value == $past(req.wdata[`CPR_CODE_MSB:`CPR_CODE_LSB]))
    else $error("channel code not taken from bits 15:4");

  AST_CODE_HOLD: assert property (
    (code_wr == 4'h0 && !codes_clear) |=>
      ($stable(channel0_code_value) && $stable(channel1_code_value) &&
       $stable(channel2_code_value) && $stable(channel3_code_value)))
    else $error("channel code changed without cause");

  AST_RESV_READ: assert property (
    (req.rd && rd_cod) |=> (rsp.valid && rsp.data[`CPR_CODE_LSB-1:0] == 4'h0))
    else $error("reserved code bits read nonzero");

  AST_ACTION_READ: assert property (
    (req.rd && addr_is(req.addr, `CPR_ADDR_SOFT_RESET)) |=> (rsp.valid && rsp.data == 16'h0000))
    else $error("soft reset register read nonzero");

  AST_RD_IDLE: assert property (
    !req.rd |=> (!rsp.valid && rsp.data == `CPR_REG_RESET))
    else $error("read answer without a read");

endmodule : cpr_regs

// ==== dv/cpr_host.sv ====
// Host model that issues register accesses and transaction ends
`timescale 1ns/1ps

module cpr_host (
  input  wire logic        mclk,
  output cpr_pkg::cpr_req_t req,
  output logic             xfer_done
);
  // Idle bus from time zero
  initial begin
    req       = '0;
    xfer_done = 1'b0;
  end

  // One access per call; release costs an edge so nothing is set twice at once
  task automatic xfer(input logic w, input logic r, input logic [6:0] a,
                      input logic [15:0] d, input logic done);
    @(posedge mclk);
    req       <= '{wr: w, rd: r, addr: a, wdata: d};
    xfer_done <= done;
    @(posedge mclk);
    req       <= '0;
    xfer_done <= 1'b0;
  endtask : xfer
endmodule : cpr_host

// ==== dv/tb_top.sv ====
// Random and corner-case test of the channel register slice
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end

module tb_top;
  logic              mclk;
  logic              nrst;
  cpr_pkg::cpr_req_t req;
  logic              xfer_done;
  cpr_pkg::cpr_rsp_t rsp;
  logic [3:0]        pwr_o;
  logic [11:0]       c0, c1, c2, c3;
  logic              clr_s, rst_s;
  int                miscompares = 0;
  int                num_checks = 0;
  logic [3:0]        pwr = 4'h0;
  logic [11:0]       code [4] = '{default: 12'h000};
  logic [6:0]        a;
  logic [15:0]       d;

  cpr_regs #(.NUM_CH(4)) dut (
    .mclk(mclk), .nrst(nrst), .req(req), .xfer_done(xfer_done), .rsp(rsp),
    .channel_power_on(pwr_o), .channel0_code_value(c0), .channel1_code_value(c1),
    .channel2_code_value(c2), .channel3_code_value(c3),
    .data_clear_strobe(clr_s), .full_reset_strobe(rst_s));
  cpr_host host (.mclk(mclk), .req(req), .xfer_done(xfer_done));

  // Expected read word from the bench's own register image
  function automatic logic [15:0] exp_rd(input logic [6:0] adr);
    if (adr == 7'h05) return {4'h0, pwr, 8'h00};
    if (adr >= 7'h07 && adr <= 7'h0a) return {code[adr - 7'h07], 4'h0};
    return 16'h0000;
  endfunction : exp_rd

  // Read answer stands only one cycle, so it is sampled just after the taking edge
  task automatic rd_chk(input logic [6:0] adr);
    host.xfer(1'b0, 1'b1, adr, 16'h0000, 1'b0);
    #1;
    `CHK(rsp, {1'b1, exp_rd(adr)})
    @(posedge mclk);
    #1;
    `CHK(rsp, {1'b0, 16'h0000})
  endtask : rd_chk

  task automatic out_chk(input logic c, input logic r);
    `CHK(pwr_o, pwr)
    `CHK({c3, c2, c1, c0}, {code[3], code[2], code[1], code[0]})
    `CHK({clr_s, rst_s}, {c, r})
  endtask : out_chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // Free-running clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    void'($urandom(79));
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    #1;
    out_chk(1'b0, 1'b0);
    rd_chk(7'h07);
    // Random writes over mapped and unmapped places; soft reset kept out here
    for (int i = 0; i < 60; i++) begin
      a = 7'h05 + 7'($urandom % 8);
      if (a == 7'h06) a = 7'h7f;
      d = 16'($urandom);
      host.xfer(1'b1, 1'b0, a, d, 1'b0);
      if (a == 7'h05) pwr = d[11:8];
      if (a >= 7'h07 && a <= 7'h0a) code[a - 7'h07] = d[15:4];
      rd_chk(7'h05 + 7'($urandom % 8));
      out_chk(1'b0, 1'b0);
    end
    // All ones: mode and reserved bits must not stick
    host.xfer(1'b1, 1'b0, 7'h05, 16'hffff, 1'b0);
    pwr = 4'hf;
    host.xfer(1'b1, 1'b0, 7'h0a, 16'hffff, 1'b0);
    code[3] = 12'hfff;
    rd_chk(7'h0a);
    rd_chk(7'h05);
    // Data clear with the transaction end in the same cycle keeps power
    host.xfer(1'b1, 1'b0, 7'h06, 16'h1000, 1'b1);
    code = '{default: 12'h000};
    #1;
    out_chk(1'b1, 1'b0);
    @(posedge mclk);
    #1;
    out_chk(1'b0, 1'b0);
    // Writing zero to the action bits changes nothing
    host.xfer(1'b1, 1'b0, 7'h08, 16'h1230, 1'b0);
    code[1] = 12'h123;
    host.xfer(1'b1, 1'b0, 7'h06, 16'h0000, 1'b1);
    #1;
    out_chk(1'b0, 1'b0);
    // Mid-run reset returns every output to zero
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    pwr = 4'h0;
    code = '{default: 12'h000};
    out_chk(1'b0, 1'b0);
    @(posedge mclk);
    nrst <= 1'b1;
    // Fill power and a code again so the full reset has work to do
    host.xfer(1'b1, 1'b0, 7'h05, 16'h0a00, 1'b0);
    pwr = 4'ha;
    host.xfer(1'b1, 1'b0, 7'h09, 16'h5670, 1'b0);
    code[2] = 12'h567;
    // Full reset stays pending until the transaction ends, reads back zero
    host.xfer(1'b1, 1'b0, 7'h06, 16'hffff, 1'b0);
    rd_chk(7'h06);
    out_chk(1'b0, 1'b0);
    host.xfer(1'b0, 1'b0, 7'h00, 16'h0000, 1'b1);
    pwr = 4'h0;
    code = '{default: 12'h000};
    #1;
    out_chk(1'b1, 1'b1);
    rd_chk(7'h05);
    // Data clear alone, pending over a later access, still keeps power
    host.xfer(1'b1, 1'b0, 7'h05, 16'h0300, 1'b0);
    pwr = 4'h3;
    host.xfer(1'b1, 1'b0, 7'h07, 16'habc0, 1'b0);
    code[0] = 12'habc;
    host.xfer(1'b1, 1'b0, 7'h06, 16'h1000, 1'b0);
    rd_chk(7'h07);
    host.xfer(1'b0, 1'b0, 7'h00, 16'h0000, 1'b1);
    code = '{default: 12'h000};
    #1;
    out_chk(1'b1, 1'b0);
    rd_chk(7'h05);
    wrap_up();
  end
endmodule : tb_top
